/* File: rtl/mac_address_lookup_table.sv */
// Hashed four-way station address lookup table with host access, learning and aging
`include "mac_lut_params.svh"
module mac_address_lookup_table (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // Source learning
  input wire logic learn_req_in,
  input wire mac_lut_pkg::key_t learn_key_in,
  input wire logic [6:0] learn_fwd_in,
  output logic learn_drop_out,
  // Destination lookup
  input wire logic lookup_req_in,
  input wire mac_lut_pkg::key_t lookup_key_in,
  input wire logic ext_static_hit_in,
  input wire logic [6:0] ext_static_fwd_in,
  output mac_lut_pkg::res_t lookup_res_out,
  output logic lookup_valid_out,
  // Aging and status
  input wire logic age_tick_in,
  output logic ready_out,
  output logic almost_full_irq_out,
  output logic write_fail_irq_out,
  output logic learn_fail_irq_out
);
  // ****************************************
  // Storage and state
  // ****************************************
  mac_lut_pkg::entry_t mem [`ENTRIES];
  logic [`ENTRIES-1:0] vld;
  mac_lut_pkg::state_t state, next_state;
  mac_lut_pkg::entry_t ent, next_ent, wd, hit_e, rd_e;
  mac_lut_pkg::key_t bkey;
  mac_lut_pkg::res_t next_lk_res;
  logic [11:0] ptr, next_ptr, wa, hit_addr, tgt_addr, dir_idx;
  logic [12:0] found_entry_total, next_total;
  logic [31:0] idx0, next_idx0, idx1, next_idx1, rd_mux, next_rdata;
  logic [1:0] op_code, next_op_code, hit_way, free_way, lru_way, tgt_way;
  logic op_go_done, next_go, entry_found, next_found, direct_addr_sel, next_direct;
  logic hash_select, next_hsel, age_pend, next_age_pend, we, vwd, rd_found;
  logic next_afull, next_wfail, next_lfail, next_ldrop, next_lk_vld;
  logic host_busy, wr_ctl, wr_idx, wr_ent, rd_ent4, any_hit, any_free, static_full, afull_cond;
  logic [9:0] bucket;
  logic [2:0] st_cnt;
  logic [3:0] way_v, way_hit, way_st;
  mac_lut_pkg::entry_t way_e [`WAYS];

  function automatic mac_lut_pkg::key_t key_of(input mac_lut_pkg::entry_t e);
    key_of = {e.w3[22:16], e.w3[15:0], e.w4};
  endfunction : key_of

  function automatic logic [9:0] hash(input mac_lut_pkg::key_t k, input logic sel);
    logic [49:0] m;
    m = {2'h0, k.mac};
    hash = sel ? (k.mac[9:0] ^ {3'h0, k.filter_group_id})
               : (m[49:40] ^ m[39:30] ^ m[29:20] ^ m[19:10] ^ m[9:0] ^ {3'h0, k.filter_group_id});
  endfunction : hash

  function automatic mac_lut_pkg::entry_t reload(input mac_lut_pkg::entry_t e);
    reload = e;
    reload.w1[`ENT_TALLY +: 3] = `TALLY_DEFAULT;
  endfunction : reload

  // ****************************************
  // Register decode
  // ****************************************
  assign host_busy = op_go_done || state != mac_lut_pkg::S_IDLE;
  assign wr_ctl = reg_wr_in && reg_addr_in == `ADDR_CTRL;
  assign wr_idx = reg_wr_in && !host_busy;
  assign wr_ent = wr_idx && reg_addr_in >= `ADDR_ENT1 && reg_addr_in <= `ADDR_ENT4;
  assign rd_ent4 = reg_rd_in && reg_addr_in == `ADDR_ENT4;
  assign rd_mux = reg_addr_in == `ADDR_IDX0 ? idx0 :
                  reg_addr_in == `ADDR_IDX1 ? idx1 :
                  reg_addr_in == `ADDR_CTRL ? {op_go_done, entry_found,
                    entry_found || !op_go_done, found_entry_total, 10'h000,
                    direct_addr_sel, hash_select, 2'h0, op_code} :
                  reg_addr_in == `ADDR_ENT1 ? ent.w1 :
                  reg_addr_in == `ADDR_ENT2 ? ent.w2 :
                  reg_addr_in == `ADDR_ENT3 ? ent.w3 :
                  reg_addr_in == `ADDR_ENT4 ? ent.w4 : 32'h00000000;

  // ****************************************
  // Bucket evaluation
  // ****************************************
  assign bkey = op_go_done ? (op_code == `OP_WRITE ? key_of(ent) : {idx0[22:0], idx1}) :
                learn_req_in ? learn_key_in : lookup_key_in;
  assign bucket = hash(bkey, hash_select);
  for (genvar w = 0; w < `WAYS; w++) begin : g_way
    assign way_e[w] = mem[{bucket, 2'(w)}];
    assign way_v[w] = vld[{bucket, 2'(w)}];
    assign way_hit[w] = way_v[w] && key_of(way_e[w]) == bkey;
    assign way_st[w] = way_v[w] && way_e[w].w1[`ENT_PIN];
  end
  assign st_cnt = {2'h0, way_st[0]} + {2'h0, way_st[1]} + {2'h0, way_st[2]} + {2'h0, way_st[3]};

  always_comb
  begin
    logic [2:0] best;
    best = 3'h7;
    hit_way = 2'h0;
    free_way = 2'h0;
    lru_way = 2'h0;
    for (int i = `WAYS - 1; i >= 0; i--)
    begin
      if (way_hit[i]) hit_way = 2'(i);
      if (!way_v[i]) free_way = 2'(i);
      if (way_v[i] && !way_st[i] && way_e[i].w1[`ENT_TALLY +: 3] <= best)
      begin
        lru_way = 2'(i);
        best = way_e[i].w1[`ENT_TALLY +: 3];
      end
    end
  end

  assign any_hit = |way_hit;
  assign any_free = ~&way_v;
  assign tgt_way = any_hit ? hit_way : any_free ? free_way : lru_way;
  assign hit_e = way_e[hit_way];
  assign hit_addr = {bucket, hit_way};
  assign tgt_addr = {bucket, tgt_way};
  assign static_full = st_cnt == `STATIC_FULL;
  assign afull_cond = !(any_hit && way_st[hit_way]) && (st_cnt == 3'h2 || st_cnt == 3'h3);
  assign dir_idx = idx1[11:0];
  assign rd_e = direct_addr_sel ? mem[dir_idx] : hit_e;
  assign rd_found = direct_addr_sel ? vld[dir_idx] : any_hit;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    next_state = state;
    next_ptr = ptr;
    next_go = op_go_done;
    next_found = entry_found;
    next_total = found_entry_total;
    next_direct = direct_addr_sel;
    next_hsel = hash_select;
    next_op_code = op_code;
    next_idx0 = idx0;
    next_idx1 = idx1;
    next_ent = ent;
    next_age_pend = age_pend;
    next_rdata = reg_rd_in ? rd_mux : reg_rdata_out;
    next_lk_res = lookup_res_out;
    {next_afull, next_wfail, next_lfail, next_ldrop, next_lk_vld} = 5'h00;
    we = 1'b0;
    wa = tgt_addr;
    wd = ent;
    vwd = 1'b1;
    if (wr_ctl && !host_busy)
    begin
      next_go = reg_wdata_in[`CTL_GO];
      next_direct = reg_wdata_in[`CTL_DIRECT];
      next_hsel = reg_wdata_in[`CTL_HSEL];
      next_op_code = reg_wdata_in[1:0];
    end
    else if (wr_ctl && !reg_wdata_in[`CTL_GO] && state != mac_lut_pkg::S_IDLE
             && state != mac_lut_pkg::S_AGE)
      next_go = 1'b0;
    if (wr_idx && reg_addr_in == `ADDR_IDX0) next_idx0 = reg_wdata_in & `MASK_IDX0;
    if (wr_idx && reg_addr_in == `ADDR_IDX1) next_idx1 = reg_wdata_in;
    if (wr_ent && reg_addr_in == `ADDR_ENT1) next_ent.w1 = reg_wdata_in & `MASK_W1;
    if (wr_ent && reg_addr_in == `ADDR_ENT2) next_ent.w2 = reg_wdata_in & `MASK_W2;
    if (wr_ent && reg_addr_in == `ADDR_ENT3) next_ent.w3 = reg_wdata_in & `MASK_W3;
    if (wr_ent && reg_addr_in == `ADDR_ENT4) next_ent.w4 = reg_wdata_in;
    unique case (state)
      mac_lut_pkg::S_IDLE:
      begin
        if (op_go_done)
        begin
          next_go = 1'b0;
          unique case (op_code)
            `OP_READ:
            begin
              next_found = rd_found;
              next_ent = rd_found ? rd_e : '0;
            end
            `OP_WRITE:
            begin
              next_found = 1'b0;
              if (!ent.w1[`ENT_PIN]) next_found = 1'b0;
              else if (direct_addr_sel)
              begin
                we = 1'b1;
                wa = dir_idx;
                next_found = 1'b1;
              end
              else if (!any_hit && static_full)
              begin
                next_wfail = 1'b1;
                next_idx0[9:0] = bucket;
              end
              else
              begin
                we = 1'b1;
                next_found = 1'b1;
                next_afull = afull_cond;
                if (afull_cond) next_idx0[11:0] = tgt_addr;
              end
            end
            `OP_SEARCH:
            begin
              next_go = 1'b1;
              next_found = 1'b0;
              next_total = 13'h0000;
              next_ptr = 12'h000;
              next_state = mac_lut_pkg::S_SEARCH;
            end
            default:
            begin
              next_found = 1'b0;
              next_ent = '0;
            end
          endcase
        end
        else if (learn_req_in && ready_out)
        begin
          if (any_hit)
          begin
            next_ldrop = hit_e.w1[`ENT_SA_DROP];
            we = !way_st[hit_way];
            wa = hit_addr;
            wd = reload(hit_e);
            wd.w2 = {hit_e.w2[31:7], learn_fwd_in} & `MASK_W2;
          end
          else if (static_full)
          begin
            next_lfail = 1'b1;
            next_idx1[9:0] = bucket;
          end
          else
          begin
            we = 1'b1;
            wd.w1 = {3'h0, `TALLY_DEFAULT, 26'h0000000};
            wd.w2 = {25'h0000000, learn_fwd_in} & `MASK_W2;
            wd.w3 = {9'h000, bkey.filter_group_id, bkey.mac[47:32]};
            wd.w4 = bkey.mac[31:0];
          end
        end
        else if (lookup_req_in && ready_out)
        begin
          next_lk_vld = 1'b1;
          if (any_hit && way_st[hit_way])
            next_lk_res = {1'b1, hit_e.w1[`ENT_DA_DROP], hit_e.w2[6:0]};
          else if (ext_static_hit_in)
            next_lk_res = {1'b1, 1'b0, ext_static_fwd_in};
          else if (any_hit)
          begin
            next_lk_res = {1'b1, hit_e.w1[`ENT_DA_DROP], hit_e.w2[6:0]};
            we = 1'b1;
            wa = hit_addr;
            wd = reload(hit_e);
          end
          else
            next_lk_res = '0;
        end
        else if (age_pend)
        begin
          next_age_pend = 1'b0;
          next_ptr = 12'h000;
          next_state = mac_lut_pkg::S_AGE;
        end
      end
      mac_lut_pkg::S_SEARCH:
      begin
        if (!next_go)
        begin
          next_state = mac_lut_pkg::S_IDLE;
          next_ent = '0;
        end
        else if (vld[ptr])
        begin
          next_ent = mem[ptr];
          next_found = 1'b1;
          next_total = found_entry_total + 13'h0001;
          next_state = mac_lut_pkg::S_SWAIT;
        end
        else if (ptr == `LAST_ENTRY)
        begin
          next_go = 1'b0;
          next_ent = '0;
          next_state = mac_lut_pkg::S_IDLE;
        end
        else next_ptr = ptr + 12'h001;
      end
      mac_lut_pkg::S_SWAIT:
      begin
        if (!next_go) next_state = mac_lut_pkg::S_IDLE;
        else if (rd_ent4)
        begin
          next_found = 1'b0;
          next_state = mac_lut_pkg::S_SEARCH;
          if (ptr == `LAST_ENTRY)
          begin
            next_go = 1'b0;
            next_ent = '0;
            next_state = mac_lut_pkg::S_IDLE;
          end
          else next_ptr = ptr + 12'h001;
        end
      end
      mac_lut_pkg::S_AGE:
      begin
        if (vld[ptr] && !mem[ptr].w1[`ENT_PIN])
        begin
          we = 1'b1;
          wa = ptr;
          wd = mem[ptr];
          if (mem[ptr].w1[`ENT_TALLY +: 3] != 3'h0)
            wd.w1[`ENT_TALLY +: 3] = mem[ptr].w1[`ENT_TALLY +: 3] - 3'h1;
          vwd = mem[ptr].w1[`ENT_TALLY +: 3] > 3'h1;
        end
        if (ptr == `LAST_ENTRY) next_state = mac_lut_pkg::S_IDLE;
        else next_ptr = ptr + 12'h001;
      end
    endcase
    if (age_tick_in) next_age_pend = 1'b1;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock_in)
    if (we) mem[wa] <= wd;

  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) vld <= '0;
    else if (we) vld[wa] <= vwd;

  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      state <= mac_lut_pkg::S_IDLE;
      {ptr, found_entry_total, op_code, idx0, idx1, ent} <= '0;
      {op_go_done, entry_found, direct_addr_sel, hash_select, age_pend} <= 5'h00;
      {reg_rdata_out, lookup_res_out, lookup_valid_out, learn_drop_out} <= '0;
      {almost_full_irq_out, write_fail_irq_out, learn_fail_irq_out, ready_out} <= 4'h0;
    end
    else
    begin
      state <= next_state;
      {ptr, found_entry_total, op_code, idx0, idx1, ent} <=
        {next_ptr, next_total, next_op_code, next_idx0, next_idx1, next_ent};
      {op_go_done, entry_found, direct_addr_sel, hash_select, age_pend} <=
        {next_go, next_found, next_direct, next_hsel, next_age_pend};
      {reg_rdata_out, lookup_res_out, lookup_valid_out, learn_drop_out} <=
        {next_rdata, next_lk_res, next_lk_vld, next_ldrop};
      {almost_full_irq_out, write_fail_irq_out, learn_fail_irq_out} <=
        {next_afull, next_wfail, next_lfail};
      ready_out <= next_state == mac_lut_pkg::S_IDLE && !next_go;
    end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  go_clear_a: assert property (state == mac_lut_pkg::S_IDLE && op_go_done
    && op_code == `OP_READ |=> !op_go_done && entry_found == $past(rd_found))
    else $error("read did not complete in one cycle");
  zero_ent_a: assert property ($fell(op_go_done) && !entry_found
    && op_code != `OP_WRITE |-> ent == '0)
    else $error("entry registers not zero without a found entry");
  flag_rd_a: assert property (reg_rd_in && reg_addr_in == `ADDR_CTRL
    |=> reg_rdata_out[`CTL_FLAG] == $past(entry_found || !op_go_done))
    else $error("flag not found or done");
  wfail_a: assert property (write_fail_irq_out |-> $past(static_full)
    && idx0[9:0] == $past(bucket))
    else $error("write fail without full static bucket");
  lfail_a: assert property (learn_fail_irq_out |-> $past(learn_req_in)
    && $past(static_full) && idx1[9:0] == $past(bucket))
    else $error("learn fail report wrong");
  afull_a: assert property (almost_full_irq_out |-> $past(st_cnt) inside {3'h2, 3'h3}
    && idx0[11:0] == $past(tgt_addr))
    else $error("almost full raised wrongly");
  search_go_a: assert property (state == mac_lut_pkg::S_IDLE && op_go_done
    && op_code == `OP_SEARCH |=> state == mac_lut_pkg::S_SEARCH && !entry_found && ptr == 12'h000)
    else $error("search did not start from the top");
  age_pin_a: assert property (state == mac_lut_pkg::S_AGE && mem[ptr].w1[`ENT_PIN] |-> !we)
    else $error("aging touched a pinned entry");
  static_wr_a: assert property (we && state == mac_lut_pkg::S_IDLE && op_go_done
    |-> wd.w1[`ENT_PIN])
    else $error("host wrote a dynamic entry");
  resume_a: assert property (state == mac_lut_pkg::S_SWAIT && op_go_done && rd_ent4
    && !(wr_ctl && !reg_wdata_in[`CTL_GO]) |=> !entry_found)
    else $error("search did not resume after entry four read");
  abort_a: assert property (state == mac_lut_pkg::S_SWAIT && wr_ctl && !reg_wdata_in[`CTL_GO]
    |=> state == mac_lut_pkg::S_IDLE && !op_go_done)
    else $error("search not aborted");
  busy_a: assert property (state == mac_lut_pkg::S_SEARCH && wr_ctl
    |=> op_code == $past(op_code))
    else $error("start accepted while busy");

  read_done_c: cover property (op_go_done && op_code == `OP_READ ##1 entry_found);
  search_hit_c: cover property (state == mac_lut_pkg::S_SEARCH ##1 state == mac_lut_pkg::S_SWAIT);
  learn_fail_c: cover property (learn_fail_irq_out);
  lookup_c: cover property (lookup_valid_out && lookup_res_out.hit);
endmodule : mac_address_lookup_table

/* File: rtl/mac_lut_params.svh */
// Register offsets, field positions and constants of the address lookup table
`ifndef MAC_LUT_PARAMS_SVH
`define MAC_LUT_PARAMS_SVH
`define ADDR_IDX0 16'h0410
`define ADDR_IDX1 16'h0414
`define ADDR_CTRL 16'h0418
`define ADDR_ENT1 16'h0420
`define ADDR_ENT2 16'h0424
`define ADDR_ENT3 16'h0428
`define ADDR_ENT4 16'h042C
`define CTL_GO 31
`define CTL_FOUND 30
`define CTL_FLAG 29
`define CTL_DIRECT 5
`define CTL_HSEL 4
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_SEARCH 2'h3
`define ENT_PIN 31
`define ENT_SA_DROP 30
`define ENT_DA_DROP 29
`define ENT_TALLY 26
`define TALLY_DEFAULT 3'h7
`define MASK_W1 32'hFC000007
`define MASK_W2 32'h8000004F
`define MASK_W3 32'h007FFFFF
`define MASK_IDX0 32'h007FFFFF
`define LAST_ENTRY 12'hFFF
`define ENTRIES 4096
`define WAYS 4
`define STATIC_FULL 3'h4
`endif

/* File: rtl/mac_lut_pkg.sv */
// Types shared by the address lookup table
package mac_lut_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_SEARCH = 4'h2,
    S_SWAIT = 4'h4,
    S_AGE = 4'h8
  } state_t;
  typedef struct packed {
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [31:0] w4;
  } entry_t;
  typedef struct packed {
    logic [6:0] filter_group_id;
    logic [47:0] mac;
  } key_t;
  typedef struct packed {
    logic hit;
    logic drop;
    logic [6:0] fwd;
  } res_t;
endpackage : mac_lut_pkg

/* File: tb/mac_lut_tb.sv */
// Self-checking bench of the address lookup table
`include "mac_lut_params.svh"
// ****************
// Bench signals
// ****************
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string n; logic [31:0] e; logic [31:0] m;} note_t;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [31:0] reg_wdata_in = 32'h00000000;
  logic [31:0] reg_rdata_out;
  logic learn_req_in = 1'b0;
  logic lookup_req_in = 1'b0;
  logic ext_static_hit_in = 1'b0;
  logic age_tick_in = 1'b0;
  mac_lut_pkg::key_t learn_key_in = '0;
  mac_lut_pkg::key_t lookup_key_in = '0;
  logic [6:0] learn_fwd_in = 7'h00;
  logic [6:0] ext_static_fwd_in = 7'h00;
  mac_lut_pkg::res_t lookup_res_out;
  logic learn_drop_out, lookup_valid_out, ready_out;
  logic almost_full_irq_out, write_fail_irq_out, learn_fail_irq_out;
  logic pend = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  int n_af = 0, n_wf = 0, n_lf = 0, n_dr = 0;
  logic [6:0] f1, f2, fd, fx;
  note_t rq[$];
  note_t lq[$];
  mac_address_lookup_table u_mac_address_lookup_table (
    .clock_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
    .learn_req_in, .learn_key_in, .learn_fwd_in, .learn_drop_out, .lookup_req_in,
    .lookup_key_in, .ext_static_hit_in, .ext_static_fwd_in, .lookup_res_out,
    .lookup_valid_out, .age_tick_in, .ready_out, .almost_full_irq_out,
    .write_fail_irq_out, .learn_fail_irq_out
  );
  always #50 clock_in = ~clock_in;
  // Event counters
  always @(posedge clock_in)
  begin
    pend <= reg_rd_in;
    n_af <= n_af + int'(almost_full_irq_out === 1'b1);
    n_wf <= n_wf + int'(write_fail_irq_out === 1'b1);
    n_lf <= n_lf + int'(learn_fail_irq_out === 1'b1);
    n_dr <= n_dr + int'(learn_drop_out === 1'b1);
  end
  // Result watcher
  always @(negedge clock_in)
  begin
    if (pend)
      cmp_reg(rq.pop_front());
    if (lookup_valid_out === 1'b1)
      cmp_res(lq.pop_front());
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cmp_reg(note_t t);
    chk(t.n, t.e & t.m, reg_rdata_out & t.m);
  endtask : cmp_reg
  task automatic cmp_res(note_t t);
    chk(t.n, t.e & t.m, {23'h0, lookup_res_out} & t.m);
  endtask : cmp_res
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic hang();
    n_fail++;
    $display("CHECK FAILED wait expected done seen timeout");
    conclude();
  endtask : hang
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [31:0] e, logic [31:0] m, string n);
    @(negedge clock_in);
    rq.push_back('{n, e, m});
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clock_in);
    reg_rd_in = 1'b0;
  endtask : rd
  task automatic poll(logic [31:0] v, logic [31:0] m);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      rd(`ADDR_CTRL, 32'h0, 32'h0000FFCC, "poll reserved");
      if ((reg_rdata_out & m) === v)
        break;
    end
    if (i == 3000)
      hang();
  endtask : poll
  task automatic wait_ready();
    int i;
    for (i = 0; i < 9000 && ready_out !== 1'b1; i++)
      @(negedge clock_in);
    if (i == 9000)
      hang();
  endtask : wait_ready
  task automatic op(logic [31:0] i1, logic [31:0] c);
    wr(`ADDR_IDX0, 32'h0);
    wr(`ADDR_IDX1, i1);
    wr(`ADDR_CTRL, c);
    poll(32'h0, 32'h80000000);
  endtask : op
  task automatic sw(logic [31:0] lo, logic [31:0] w1, logic [6:0] f);
    op(lo, 32'h80000012);
    wr(`ADDR_ENT1, w1);
    wr(`ADDR_ENT2, {25'h0, f});
    wr(`ADDR_ENT3, 32'h0);
    wr(`ADDR_ENT4, lo);
    op(lo, 32'h80000011);
  endtask : sw
  task automatic learn(logic [31:0] lo, logic [6:0] f);
    wait_ready();
    learn_key_in = {23'h0, lo};
    learn_fwd_in = f;
    learn_req_in = 1'b1;
    @(negedge clock_in);
    learn_req_in = 1'b0;
    @(negedge clock_in);
  endtask : learn
  task automatic look(logic [31:0] lo, logic h, logic [6:0] f, logic [8:0] e, logic [8:0] m);
    wait_ready();
    lq.push_back('{"lookup", {23'h0, e}, {23'h0, m}});
    lookup_key_in = {23'h0, lo};
    ext_static_hit_in = h;
    ext_static_fwd_in = f;
    lookup_req_in = 1'b1;
    @(negedge clock_in);
    lookup_req_in = 1'b0;
    @(negedge clock_in);
  endtask : look
  task automatic age();
    wait_ready();
    age_tick_in = 1'b1;
    @(negedge clock_in);
    age_tick_in = 1'b0;
    @(negedge clock_in);
    wait_ready();
  endtask : age
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    logic [15:0] ra [8];
    logic [31:0] mk [5];
    ra = '{`ADDR_IDX0, `ADDR_IDX1, `ADDR_CTRL, `ADDR_ENT1, `ADDR_ENT2, `ADDR_ENT3,
      `ADDR_ENT4, 16'h0400};
    mk = '{32'h00010005, 32'h00020005, 32'h00030005, 32'h00040005, 32'h0ABC0009};
    void'($urandom(32'h1436));
    f1 = 7'($urandom) & 7'h4F;
    f2 = 7'($urandom) & 7'h4F;
    fd = 7'($urandom) & 7'h4F;
    fx = fd ^ 7'h4F;
    repeat (4) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk("ready", 32'h1, {31'h0, ready_out});
    foreach (ra[i])
      rd(ra[i], (ra[i] == `ADDR_CTRL) ? 32'h20000000 : 32'h0, 32'hFFFFFFFF, "reset value");
    sw(32'h00090005, 32'h0, 7'h01);
    rd(`ADDR_CTRL, 32'h20000000, 32'hE0000000, "unpinned write");
    sw(mk[0], 32'hC0000000, f1);
    sw(mk[1], 32'hA0000000, f2);
    sw(mk[2], 32'h80000000, 7'h00);
    rd(`ADDR_IDX0, 32'h016, 32'hFFF, "almost full addr");
    sw(mk[3], 32'h80000000, 7'h00);
    rd(`ADDR_IDX0, 32'h017, 32'hFFF, "almost full addr");
    sw(32'h00050005, 32'h80000000, 7'h00);
    rd(`ADDR_IDX0, 32'h005, 32'h3FF, "write fail bucket");
    rd(`ADDR_CTRL, 32'h0, 32'h40000000, "write fail found");
    chk("almost full", 32'd2, n_af);
    chk("write fail", 32'd1, n_wf);
    wr(`ADDR_IDX1, 32'h0);
    learn(mk[2], fd);
    learn(mk[0], fd);
    learn(32'h00090005, fd);
    learn(mk[4], fd);
    rd(`ADDR_IDX1, 32'h005, 32'h3FF, "learn fail bucket");
    chk("learn fail", 32'd1, n_lf);
    chk("source drop", 32'd1, n_dr);
    look(mk[4], 1'b0, fx, {2'b10, fd}, 9'h1FF);
    look(mk[4], 1'b1, fx, {2'b10, fx}, 9'h1FF);
    look(mk[1], 1'b1, fx, {2'b11, f2}, 9'h1FF);
    look(32'h0ABC0007, 1'b0, fx, 9'h000, 9'h100);
    op(32'h300, 32'h80000032);
    rd(`ADDR_CTRL, 32'h20000000, 32'hE0000000, "empty read");
    for (int i = 3; i < 7; i++)
      rd(ra[i], 32'h0, 32'hFFFFFFFF, "empty entry");
    op(32'h014, 32'h80000032);
    rd(`ADDR_CTRL, 32'h60000000, 32'hE0000000, "direct read");
    rd(`ADDR_ENT1, 32'hC0000000, 32'hFFFFFFFF, "direct word1");
    rd(`ADDR_ENT2, {25'h0, f1}, 32'hFFFFFFFF, "direct word2");
    rd(`ADDR_ENT4, mk[0], 32'hFFFFFFFF, "direct word4");
    op(32'h024, 32'h80000032);
    rd(`ADDR_ENT1, 32'h1C000000, 32'hFC000000, "learned word1");
    wr(`ADDR_CTRL, 32'h80000003);
    rd(`ADDR_CTRL, 32'h80000000, 32'hC0000000, "search start");
    for (int i = 0; i < 5; i++)
    begin
      poll(32'hC0000000, 32'hC0000000);
      if (i == 0)
        wr(`ADDR_ENT4, 32'h0);
      rd(`ADDR_ENT1, {i < 4, 31'h0}, 32'h80000000, "search word1");
      rd(`ADDR_ENT4, mk[i], 32'hFFFFFFFF, "search word4");
    end
    poll(32'h0, 32'h80000000);
    rd(`ADDR_CTRL, 32'h20050000, 32'hFFFF0000, "search end");
    rd(`ADDR_ENT1, 32'h0, 32'hFFFFFFFF, "search end word1");
    wr(`ADDR_CTRL, 32'h80000003);
    poll(32'hC0000000, 32'hC0000000);
    wr(`ADDR_CTRL, 32'h00000003);
    rd(`ADDR_CTRL, 32'h0, 32'h80000000, "abort");
    age();
    op(32'h024, 32'h80000032);
    rd(`ADDR_ENT1, 32'h18000000, 32'h1C000000, "aged tally");
    repeat (7) age();
    op(32'h024, 32'h80000032);
    rd(`ADDR_CTRL, 32'h20000000, 32'hE0000000, "aged out");
    op(32'h014, 32'h80000032);
    rd(`ADDR_CTRL, 32'h60000000, 32'hE0000000, "pinned kept");
    conclude();
  end
endmodule : testbench
